/* File: bench/flash_dev_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// behavioural flash device on the far side of the host bus
// ----------------------------------------------------------------
module flash_dev_model #(
  parameter logic [15:0] MAKER_CODE = 16'h00A5, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h5AC3, // arbitrary value
  parameter logic [4:0] PROT_SECT = 5'h1F,
  parameter int PROG_READS = 3,
  parameter int ERASE_READS = 4
) (
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [16:0] addr,
  input wire logic host_oe,
  input wire logic [15:0] host_dq,
  input wire logic byte_mode,
  input wire logic fail_mode,
  output logic [15:0] dq_line,
  output logic ready_busy,
  output int resets
);
  logic [15:0] mem [logic [16:0]];
  logic [16:0] lat_addr = 17'h00000;
  logic [15:0] dout = 16'h0000;
  logic [15:0] pd = 16'h0000;
  logic [4:0] sect = 5'h00;
  logic ident = 1'b0, susp = 1'b0, prog_b = 1'b0, erase_b = 1'b0, chip = 1'b0, tog = 1'b0;
  int step = 0, pleft = 0, eleft = 0;
  wire ws = ce_n | we_n;
  wire rs = ce_n | oe_n;
  wire [16:0] u1 = byte_mode ? 17'h00AAA : 17'h00555;
  wire [16:0] u2 = byte_mode ? 17'h00555 : 17'h002AA;
  wire erasing = erase_b && !susp;
  wire busy = prog_b || erasing;
  // pull-up pin, low only while an algorithm runs
  assign ready_busy = busy ? 1'b0 : 1'b1;
  // a released bus shows the inverse of the last value
  assign dq_line = !rs ? dout : (host_oe ? host_dq : ~dout);
  initial resets = 0;
  // address taken at the later falling strobe edge
  always @(negedge ws) lat_addr = addr;
  // data taken at the earlier rising strobe edge, low byte decoded
  always @(posedge ws)
  begin : decode
    logic [7:0] d;
    d = host_dq[7:0];
    if (busy)
    begin
      if (fail_mode && d == 8'hF0)
      begin
        prog_b = 1'b0;
        erase_b = 1'b0;
        resets++;
      end
      else if (erasing && !chip && !prog_b && d == 8'hB0) susp = 1'b1;
      step = 0;
    end
    else
      case (step)
        0:
        begin
          if (d == 8'hF0) ident = 1'b0;
          if (d == 8'hF0) resets++;
          else if (susp && d == 8'h30) susp = 1'b0;
          else if (lat_addr == u1 && d == 8'hAA) step = 1;
        end
        1: step = (lat_addr == u2 && d == 8'h55) ? 2 : 0;
        2:
        begin
          if (lat_addr == u1 && d == 8'h90) ident = 1'b1;
          step = lat_addr != u1 ? 0 : d == 8'hA0 ? 3 : (d == 8'h80 && !susp) ? 4 : 0;
        end
        3:
        begin
          pd = host_dq;
          // a protected sector shows status for a while but keeps its data
          if (!(susp && lat_addr[16:12] == sect) && lat_addr[16:12] != PROT_SECT)
            mem[lat_addr] = host_dq;
          prog_b = 1'b1;
          pleft = PROG_READS;
          step = 0;
        end
        4: step = (lat_addr == u1 && d == 8'hAA) ? 5 : 0;
        5: step = (lat_addr == u2 && d == 8'h55) ? 6 : 0;
        default:
        begin
          chip = (d == 8'h10 && lat_addr == u1);
          erase_b = chip || d == 8'h30;
          if (chip) mem.delete();
          else sect = lat_addr[16:12];
          // a protected sector keeps its data in a sector erase; a chip erase clears every sector
          for (int i = 0; i < 4096; i++)
            if (!chip && erase_b && sect != PROT_SECT && mem.exists({sect, i[11:0]}))
              mem.delete({sect, i[11:0]});
          eleft = ERASE_READS;
          step = 0;
        end
      endcase
  end
  // each read start presents status or data
  always @(negedge rs)
  begin
    if (busy) tog = ~tog;
    if (ident) dout = addr[1:0] == 2'h0 ? MAKER_CODE :
      addr[1:0] == (byte_mode ? 2'h2 : 2'h1) ? PART_CODE :
      {15'h0000, addr[16:12] == PROT_SECT};
    else if (prog_b) dout = {8'h00, ~pd[7], tog, fail_mode, 5'h00};
    else if (erasing) dout = {8'h00, 1'b0, tog, fail_mode, 5'h00};
    else if (erase_b && addr[16:12] == sect) dout = 16'h0080;
    else dout = mem.exists(addr) ? mem[addr] : 16'hFFFF;
  end
  // completion counted in reads, so status is seen a few times
  always @(posedge rs)
  begin
    if (prog_b && !fail_mode) pleft--;
    if (prog_b && !fail_mode && pleft <= 0) prog_b = 1'b0;
    else if (erasing && !prog_b && !fail_mode) eleft--;
    if (erasing && !prog_b && eleft <= 0) erase_b = 1'b0;
  end
endmodule

/* File: bench/flash_host_test.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module flash_host_test;
  localparam logic [15:0] MAKER = 16'h00A5; // arbitrary value
  localparam logic [15:0] PART = 16'h5AC3; // arbitrary value
  logic CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h00000000, PRDATA, rv;
  logic PREADY, PSLVERR, FL_CE_N, FL_WE_N, FL_OE_N, FL_DQ_OE, FL_READY_BUSY_I, serr;
  logic [16:0] FL_ADDR;
  logic [15:0] FL_DQ_O, FL_DQ_I;
  logic bm = 1'b0, fm = 1'b0;
  int resets, r, error_cnt = 0, checks = 0;
  always #12.5 CLK = ~CLK;
  flash_host u_flash_host (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .FL_ADDR(FL_ADDR), .FL_CE_N(FL_CE_N), .FL_WE_N(FL_WE_N),
    .FL_OE_N(FL_OE_N), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE(FL_DQ_OE), .FL_DQ_I(FL_DQ_I),
    .FL_READY_BUSY_I(FL_READY_BUSY_I));
  flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_flash_dev_model (.ce_n(FL_CE_N),
    .we_n(FL_WE_N), .oe_n(FL_OE_N), .addr(FL_ADDR), .host_oe(FL_DQ_OE), .host_dq(FL_DQ_O),
    .byte_mode(bm), .fail_mode(fm), .dq_line(FL_DQ_I), .ready_busy(FL_READY_BUSY_I),
    .resets(resets));
  // verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin @(posedge CLK); n++; end while (PREADY !== 1'b1 && n < 50);
    rv = PRDATA;
    serr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 50) error_cnt++;
    if (n >= 50) results();
    @(posedge CLK);
  endtask
  // start a command and wait for the busy bit to clear
  task automatic op(input logic [3:0] c, input logic [16:0] a, input logic [15:0] d);
    int n;
    n = 0;
    apb(1'b1, flash_host_pkg::OFS_ADDR, {15'h0000, a});
    apb(1'b1, flash_host_pkg::OFS_WDATA, {16'h0000, d});
    apb(1'b1, flash_host_pkg::OFS_CMD, {28'h0000000, c});
    do begin apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0); n++; end
    while (rv[flash_host_pkg::ST_BUSY] !== 1'b0 && n < 400);
    if (n >= 400) error_cnt++;
    if (n >= 400) results();
  endtask
  // poll an address and compare the data that follows
  task automatic pchk(input logic [16:0] a, input logic [15:0] d, input logic [15:0] e);
    op(flash_host_pkg::OP_POLL, a, d);
    apb(1'b0, flash_host_pkg::OFS_RDATA, 32'h0);
    `CHK(rv[15:0], e)
  endtask
  initial
  begin
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
    `CHK(rv[6:0], 7'h10)
    apb(1'b0, 8'h20, 32'h0);
    `CHK({serr, rv}, {1'b1, 32'h0})
    op(flash_host_pkg::OP_IDENT, 17'h00000, 16'h0000);
    apb(1'b0, flash_host_pkg::OFS_RDATA, 32'h0);
    `CHK(rv[15:0], MAKER)
    op(flash_host_pkg::OP_IDENT, 17'h00001, 16'h0000);
    apb(1'b0, flash_host_pkg::OFS_RDATA, 32'h0);
    `CHK(rv[15:0], PART)
    op(flash_host_pkg::OP_IDENT, 17'h1F002, 16'h0000);
    apb(1'b0, flash_host_pkg::OFS_RDATA, 32'h0);
    `CHK(rv[15:0], 16'h0001)
    op(flash_host_pkg::OP_RESET, 17'h00000, 16'h0000);
    op(flash_host_pkg::OP_READ, 17'h00000, 16'h0000);
    apb(1'b0, flash_host_pkg::OFS_RDATA, 32'h0);
    `CHK(rv[15:0], 16'hFFFF)
    op(flash_host_pkg::OP_PROGRAM, 17'h01234, 16'h5A3C);
    apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
    `CHK(rv[flash_host_pkg::ST_READY_PIN], 1'b0)
    op(flash_host_pkg::OP_PROGRAM, 17'h01234, 16'h5A3C);
    `CHK(rv[flash_host_pkg::ST_REFUSED], 1'b1)
    pchk(17'h01234, 16'h5A3C, 16'h5A3C);
    apb(1'b1, flash_host_pkg::OFS_CFG, 32'h1);
    bm <= 1'b1;
    pchk(17'h00100, 16'h00C3, 16'hFFFF);
    op(flash_host_pkg::OP_PROGRAM, 17'h00100, 16'h00C3);
    pchk(17'h00100, 16'h00C3, 16'h00C3);
    apb(1'b1, flash_host_pkg::OFS_CFG, 32'h0);
    bm <= 1'b0;
    op(flash_host_pkg::OP_SECTOR_ERASE, 17'h01234, 16'h0000);
    apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
    `CHK(rv[5:4], 2'b10)
    op(flash_host_pkg::OP_SUSPEND, 17'h00000, 16'h0000);
    apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
    `CHK({rv[6], rv[4]}, 2'b11)
    op(flash_host_pkg::OP_PROGRAM, 17'h05000, 16'h1234);
    pchk(17'h05000, 16'h1234, 16'h1234);
    op(flash_host_pkg::OP_RESUME, 17'h00000, 16'h0000);
    pchk(17'h01234, 16'h0000, 16'hFFFF);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, flash_host_pkg::OFS_STATUS, 32'hE);
      op(i == 0 ? 4'h6 : i == 1 ? 4'h7 : 4'h9, 17'h00000, 16'h0000);
      `CHK(rv[flash_host_pkg::ST_REFUSED], 1'b1)
    end
    op(flash_host_pkg::OP_CHIP_ERASE, 17'h00000, 16'h0000);
    pchk(17'h05000, 16'h0000, 16'hFFFF);
    op(flash_host_pkg::OP_PROGRAM, 17'h1F000, 16'h00A5);
    pchk(17'h1F000, 16'h00A5, 16'hFFFF);
    fm <= 1'b1;
    r = resets;
    op(flash_host_pkg::OP_PROGRAM, 17'h02000, 16'h0055);
    op(flash_host_pkg::OP_POLL, 17'h02000, 16'h0055);
    fm <= 1'b0;
    `CHK({rv[flash_host_pkg::ST_FAIL], resets == r + 1}, 2'b11)
    results();
  end
endmodule

/* File: rtl/flash_host.sv */
`timescale 1ns/1ps
module flash_host #(
  parameter int ADDR_W = 17
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [ADDR_W-1:0] FL_ADDR,
  output logic FL_CE_N,
  output logic FL_WE_N,
  output logic FL_OE_N,
  output logic [15:0] FL_DQ_O,
  output logic FL_DQ_OE,
  input wire logic [15:0] FL_DQ_I,
  input wire logic FL_READY_BUSY_I
);
  initial
  begin
    if (ADDR_W != 17) $error("ADDR_W must be 17");
  end

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SETUP = 3'b001,
    S_STRB = 3'b011,
    S_GAP = 3'b010
  } bus_type;

  // ----------------------------------------------------------------
  // command sequence tables
  // ----------------------------------------------------------------
  // number of write cycles for each operation
  function automatic logic [2:0] n_writes(input logic [3:0] op);
    unique case (op)
      flash_host_pkg::OP_PROGRAM: n_writes = 3'h4;
      flash_host_pkg::OP_IDENT: n_writes = 3'h3;
      flash_host_pkg::OP_CHIP_ERASE, flash_host_pkg::OP_SECTOR_ERASE: n_writes = 3'h6;
      flash_host_pkg::OP_RESET, flash_host_pkg::OP_SUSPEND,
      flash_host_pkg::OP_RESUME: n_writes = 3'h1;
      default: n_writes = 3'h0;
    endcase
  endfunction

  // address and low data byte of write step i
  function automatic logic [24:0] step(input logic [3:0] op, input logic [2:0] i,
                                       input logic bm, input logic [16:0] a,
                                       input logic [7:0] d);
    logic [16:0] u1;
    logic [16:0] u2;
    u1 = bm ? flash_host_pkg::UA1_BYTE : flash_host_pkg::UA1_WORD;
    u2 = bm ? flash_host_pkg::UA2_BYTE : flash_host_pkg::UA2_WORD;
    step = {u1, flash_host_pkg::FC_UNLOCK1};
    unique case (op)
      flash_host_pkg::OP_RESET: step = {17'h00000, flash_host_pkg::FC_RESET};
      flash_host_pkg::OP_SUSPEND: step = {17'h00000, flash_host_pkg::FC_SUSPEND};
      flash_host_pkg::OP_RESUME: step = {17'h00000, flash_host_pkg::FC_RESUME};
      default:
      begin
        if (i == 3'h1 || i == 3'h4) step = {u2, flash_host_pkg::FC_UNLOCK2};
        else if (i == 3'h2 && op == flash_host_pkg::OP_PROGRAM)
          step = {u1, flash_host_pkg::FC_PROGRAM};
        else if (i == 3'h2 && op == flash_host_pkg::OP_IDENT)
          step = {u1, flash_host_pkg::FC_IDENT};
        else if (i == 3'h2) step = {u1, flash_host_pkg::FC_ERASE_SETUP};
        else if (i == 3'h3 && op == flash_host_pkg::OP_PROGRAM) step = {a, d};
        else if (i == 3'h5 && op == flash_host_pkg::OP_CHIP_ERASE)
          step = {u1, flash_host_pkg::FC_CHIP};
        else if (i == 3'h5) step = {a[16:12], 12'h000, flash_host_pkg::FC_SECTOR};
      end
    endcase
  endfunction

  // ----------------------------------------------------------------
  // register file and APB slave
  // ----------------------------------------------------------------
  logic [3:0] op_reg;
  logic [16:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic byte_mode_reg;
  logic done_reg;
  logic fail_reg;
  logic refused_reg;
  logic erase_pend_reg;
  logic susp_reg;
  logic prog_poll_reg;
  logic busy;
  logic ready_pin;
  logic wr_en;
  logic go;
  logic accept;
  logic set_done;
  logic set_fail;
  logic [3:0] cmd_in;
  logic [31:0] status_word;

  assign PREADY = 1'b1;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign cmd_in = PWDATA[3:0];
  assign go = wr_en && PADDR == flash_host_pkg::OFS_CMD;
  // ignore commands while busy, suspend/resume only in the right state
  always_comb
  begin
    accept = !busy && cmd_in <= flash_host_pkg::OP_POLL;
    if (!ready_pin && !susp_reg && cmd_in != flash_host_pkg::OP_POLL
        && cmd_in != flash_host_pkg::OP_SUSPEND)
      accept = 1'b0;
    if (cmd_in == flash_host_pkg::OP_SUSPEND && (!erase_pend_reg || susp_reg))
      accept = 1'b0;
    if (cmd_in == flash_host_pkg::OP_RESUME && !susp_reg)
      accept = 1'b0;
  end

  assign status_word = {25'h0000000, susp_reg, erase_pend_reg, ready_pin, refused_reg,
                        fail_reg, done_reg, busy};
  // read mux with error on unmapped word
  always_comb
  begin
    PRDATA = 32'h00000000;
    PSLVERR = 1'b0;
    unique case (PADDR)
      flash_host_pkg::OFS_CMD: PRDATA = {28'h0000000, op_reg};
      flash_host_pkg::OFS_ADDR: PRDATA = {15'h0000, addr_reg};
      flash_host_pkg::OFS_WDATA: PRDATA = {16'h0000, wdata_reg};
      flash_host_pkg::OFS_RDATA: PRDATA = {16'h0000, rdata_reg};
      flash_host_pkg::OFS_STATUS: PRDATA = status_word;
      flash_host_pkg::OFS_CFG: PRDATA = {31'h00000000, byte_mode_reg};
      default: PSLVERR = PSEL && PENABLE;
    endcase
  end

  // plain configuration registers
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      addr_reg <= 17'h00000;
      wdata_reg <= 16'h0000;
      byte_mode_reg <= 1'b0;
      op_reg <= 4'h0;
    end
    else
    begin
      if (wr_en && PADDR == flash_host_pkg::OFS_ADDR) addr_reg <= PWDATA[16:0];
      if (wr_en && PADDR == flash_host_pkg::OFS_WDATA) wdata_reg <= PWDATA[15:0];
      if (wr_en && PADDR == flash_host_pkg::OFS_CFG)
        byte_mode_reg <= PWDATA[flash_host_pkg::CFG_BYTE_MODE];
      if (go && accept) op_reg <= cmd_in;
      // a failed poll turns the operation into the reset write
      if (set_fail) op_reg <= flash_host_pkg::OP_RESET;
    end
  end

  // sticky flags, write one to clear, set wins
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      refused_reg <= 1'b0;
    end
    else
    begin
      if (wr_en && PADDR == flash_host_pkg::OFS_STATUS)
      begin
        if (PWDATA[flash_host_pkg::ST_DONE]) done_reg <= 1'b0;
        if (PWDATA[flash_host_pkg::ST_FAIL]) fail_reg <= 1'b0;
        if (PWDATA[flash_host_pkg::ST_REFUSED]) refused_reg <= 1'b0;
      end
      if (set_done) done_reg <= 1'b1;
      if (set_fail) fail_reg <= 1'b1;
      if (go && !accept) refused_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  logic [16:0] s1_reg;
  logic [16:0] s2_reg;
  logic [16:0] s3_reg;
  logic [16:0] flt_reg;
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s1_reg <= 17'h10000;
      s2_reg <= 17'h10000;
      s3_reg <= 17'h10000;
      flt_reg <= 17'h10000;
    end
    else
    begin
      s1_reg <= {FL_READY_BUSY_I, FL_DQ_I};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int b = 0; b < 17; b++)
        if (s2_reg[b] == s3_reg[b]) flt_reg[b] <= s3_reg[b];
    end
  end
  assign ready_pin = flt_reg[16];

  // ----------------------------------------------------------------
  // bus cycle sequencer
  // ----------------------------------------------------------------
  bus_type state_reg;
  logic [2:0] idx_reg;
  logic [2:0] nw_reg;
  logic [3:0] cnt_reg;
  logic is_rd_reg;
  logic rd_pend_reg;
  logic poll_reg;
  logic rechk_reg;
  logic final_reg;
  logic exp7_reg;
  logic [24:0] cur;
  logic [7:0] rd;
  logic [3:0] strb_len;

  assign busy = state_reg != S_IDLE;
  assign cur = step(op_reg, idx_reg, byte_mode_reg, addr_reg, wdata_reg[7:0]);
  assign rd = flt_reg[7:0];
  assign strb_len = is_rd_reg ? 4'(flash_host_pkg::RD_CYC) : 4'(flash_host_pkg::WP_CYC);

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_reg <= S_IDLE;
      idx_reg <= 3'h0;
      nw_reg <= 3'h0;
      cnt_reg <= 4'h0;
      is_rd_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      poll_reg <= 1'b0;
      rechk_reg <= 1'b0;
      final_reg <= 1'b0;
      exp7_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      FL_CE_N <= 1'b1;
      FL_WE_N <= 1'b1;
      FL_OE_N <= 1'b1;
      FL_DQ_OE <= 1'b0;
      FL_DQ_O <= 16'h0000;
      FL_ADDR <= 17'h00000;
    end
    else
    begin
      unique case (state_reg)
        S_IDLE:
        if (go && accept)
        begin
          nw_reg <= n_writes(cmd_in);
          idx_reg <= 3'h0;
          is_rd_reg <= n_writes(cmd_in) == 3'h0;
          // identify ends in one read; a read needs no writes
          rd_pend_reg <= cmd_in == flash_host_pkg::OP_IDENT;
          poll_reg <= cmd_in == flash_host_pkg::OP_POLL;
          rechk_reg <= 1'b0;
          final_reg <= 1'b0;
          exp7_reg <= prog_poll_reg ? wdata_reg[7] : 1'b1;
          state_reg <= S_SETUP;
        end
        S_SETUP:
        begin
          // address and data settle before the strobe falls
          FL_CE_N <= 1'b0;
          FL_ADDR <= is_rd_reg ? addr_reg : cur[24:8];
          FL_DQ_OE <= !is_rd_reg;
          FL_DQ_O <= (op_reg == flash_host_pkg::OP_PROGRAM && idx_reg == 3'h3
                      && !byte_mode_reg) ? wdata_reg : {8'h00, cur[7:0]};
          cnt_reg <= 4'h0;
          state_reg <= S_STRB;
        end
        S_STRB:
        begin
          FL_WE_N <= is_rd_reg;
          FL_OE_N <= !is_rd_reg;
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == strb_len)
          begin
            // strobe rises with address and data still held
            FL_WE_N <= 1'b1;
            FL_OE_N <= 1'b1;
            if (is_rd_reg) rdata_reg <= flt_reg[15:0];
            cnt_reg <= 4'h0;
            state_reg <= S_GAP;
          end
        end
        S_GAP:
        begin
          FL_CE_N <= 1'b1;
          FL_DQ_OE <= 1'b0;
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg + 4'h1 >= 4'(flash_host_pkg::GAP_CYC))
          begin
            state_reg <= S_SETUP;
            if (!is_rd_reg && idx_reg + 3'h1 < nw_reg)
              idx_reg <= idx_reg + 3'h1;
            else if (!is_rd_reg && (rd_pend_reg || poll_reg))
              is_rd_reg <= 1'b1;
            else if (!is_rd_reg || !poll_reg || final_reg)
              state_reg <= S_IDLE;
            else if (rd[7] == exp7_reg)
              final_reg <= 1'b1;
            else if (rd[5] && !rechk_reg)
              rechk_reg <= 1'b1;
            else if (rechk_reg)
            begin
              // still not done after timeout: write the reset command
              nw_reg <= 3'h1;
              idx_reg <= 3'h0;
              is_rd_reg <= 1'b0;
              poll_reg <= 1'b0;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  assign set_done = state_reg == S_GAP && cnt_reg + 4'h1 >= 4'(flash_host_pkg::GAP_CYC)
                    && is_rd_reg && (!poll_reg || final_reg);
  assign set_fail = state_reg == S_GAP && cnt_reg + 4'h1 >= 4'(flash_host_pkg::GAP_CYC)
                    && is_rd_reg && poll_reg && !final_reg && rechk_reg
                    && rd[7] != exp7_reg;

  // erase and suspend tracking for command gating
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      erase_pend_reg <= 1'b0;
      susp_reg <= 1'b0;
      prog_poll_reg <= 1'b0;
    end
    else if (go && accept)
    begin
      unique case (cmd_in)
        flash_host_pkg::OP_SECTOR_ERASE: erase_pend_reg <= 1'b1;
        flash_host_pkg::OP_SUSPEND: susp_reg <= 1'b1;
        flash_host_pkg::OP_RESUME: susp_reg <= 1'b0;
        flash_host_pkg::OP_RESET:
        begin
          erase_pend_reg <= susp_reg;
        end
        default:
        begin
        end
      endcase
      if (cmd_in == flash_host_pkg::OP_PROGRAM) prog_poll_reg <= 1'b1;
      if (cmd_in == flash_host_pkg::OP_CHIP_ERASE || cmd_in == flash_host_pkg::OP_SECTOR_ERASE)
        prog_poll_reg <= 1'b0;
      // a resumed erase is polled for erase completion again
      if (cmd_in == flash_host_pkg::OP_RESUME) prog_poll_reg <= 1'b0;
    end
    else if ((set_done && poll_reg && !susp_reg) || set_fail)
      erase_pend_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence we_low;
    !FL_WE_N;
  endsequence
  sequence fail_seen;
    set_fail;
  endsequence
  a_we_under_ce: assert property (@(posedge CLK) disable iff (!RST_N)
    we_low |-> !FL_CE_N && FL_DQ_OE && FL_OE_N) else $error("write strobe without select");
  a_addr_held_we: assert property (@(posedge CLK) disable iff (!RST_N)
    !FL_WE_N |=> $stable(FL_ADDR)) else $error("address moved during write");
  a_data_held_we: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(FL_WE_N) |-> $stable(FL_DQ_O) && FL_DQ_OE) else $error("data moved at strobe rise");
  a_upper_byte_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    !FL_WE_N && op_reg != flash_host_pkg::OP_PROGRAM |-> FL_DQ_O[15:8] == 8'h00)
    else $error("upper byte driven in command");
  a_fail_resets: assert property (@(posedge CLK) disable iff (!RST_N)
    fail_seen |-> ##[1:20] (!FL_WE_N && FL_DQ_O[7:0] == flash_host_pkg::FC_RESET))
    else $error("no reset after failure");
  a_suspend_gated: assert property (@(posedge CLK) disable iff (!RST_N)
    go && cmd_in == flash_host_pkg::OP_SUSPEND && !erase_pend_reg |=> refused_reg)
    else $error("suspend taken without erase");
  a_resume_gated: assert property (@(posedge CLK) disable iff (!RST_N)
    go && cmd_in == flash_host_pkg::OP_RESUME && !susp_reg |=> refused_reg && !$rose(busy))
    else $error("resume taken while not suspended");
  a_busy_ignored: assert property (@(posedge CLK) disable iff (!RST_N)
    go && !ready_pin && !susp_reg && cmd_in == flash_host_pkg::OP_PROGRAM
    |=> refused_reg && !$rose(busy)) else $error("command issued while busy");
  a_done_final_read: assert property (@(posedge CLK) disable iff (!RST_N)
    set_done && poll_reg |-> final_reg && $past(FL_OE_N, 2) == 1'b0)
    else $error("poll finished without final read");
endmodule

/* File: shared/flash_host_pkg.sv */
package flash_host_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses of 32-bit words)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CFG = 8'h14;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_READY_PIN = 4;
  localparam int ST_ERASE_PEND = 5;
  localparam int ST_SUSPENDED = 6;
  localparam int CFG_BYTE_MODE = 0;
  // ----------------------------------------------------------------
  // host command codes written to the command register
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_RESET = 4'h1,
    OP_IDENT = 4'h2,
    OP_PROGRAM = 4'h3,
    OP_CHIP_ERASE = 4'h4,
    OP_SECTOR_ERASE = 4'h5,
    OP_SUSPEND = 4'h6,
    OP_RESUME = 4'h7,
    OP_POLL = 4'h8
  } op_type;
  // ----------------------------------------------------------------
  // flash command bytes and unlock addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] FC_UNLOCK1 = 8'hAA;
  localparam logic [7:0] FC_UNLOCK2 = 8'h55;
  localparam logic [7:0] FC_PROGRAM = 8'hA0;
  localparam logic [7:0] FC_ERASE_SETUP = 8'h80;
  localparam logic [7:0] FC_CHIP = 8'h10;
  localparam logic [7:0] FC_SECTOR = 8'h30;
  localparam logic [7:0] FC_IDENT = 8'h90;
  localparam logic [7:0] FC_RESET = 8'hF0;
  localparam logic [7:0] FC_SUSPEND = 8'hB0;
  localparam logic [7:0] FC_RESUME = 8'h30;
  localparam logic [16:0] UA1_WORD = 17'h00555;
  localparam logic [16:0] UA2_WORD = 17'h002AA;
  localparam logic [16:0] UA1_BYTE = 17'h00AAA;
  localparam logic [16:0] UA2_BYTE = 17'h00555;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 25;
  localparam int T_WP_NS = 50;
  localparam int T_ACC_NS = 70;
  localparam int T_GAP_NS = 20;
  localparam int SYNC_CYC = 3;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
  localparam int GAP_CYC = ((T_GAP_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 :
                           (T_GAP_NS + CLK_NS - 1) / CLK_NS;
endpackage
